/* core/fc_defines.svh */
// Purpose: constants of the flash command sequencer
// Assumes: 50 MHz clock, AXI4-Lite byte addresses
// Notes:   timing counts derive from times in ns, poll limit from ms
`ifndef FC_DEFINES_SVH
`define FC_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FC_REG_CMD     32'h0000_0000
`define FC_REG_ADDR    32'h0000_0004
`define FC_REG_WDATA   32'h0000_0008
`define FC_REG_STATUS  32'h0000_000c
`define FC_REG_RDATA   32'h0000_0010

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define FC_ST_BUSY     0
`define FC_ST_DONE     1
`define FC_ST_ERR_TO   2
`define FC_ST_ERR_CHK  3
`define FC_ST_ERR_OP   4
`define FC_ST_LOCKED   5

// ----------------------------------------
// command addresses and data
// ----------------------------------------
`define FC_ADDR_U1     17'h05555
`define FC_ADDR_U2     17'h02aaa
`define FC_ADDR_LOCKQ  17'h00002
`define FC_ADDR_ANY    17'h00000
`define FC_DAT_U1      8'haa
`define FC_DAT_U2      8'h55
`define FC_CMD_PROG    8'ha0
`define FC_CMD_SETUP   8'h80
`define FC_CMD_ERASE   8'h10
`define FC_CMD_LOCK    8'h40
`define FC_CMD_ID      8'h90
`define FC_CMD_EXIT    8'hf0
`define FC_OP_LAST     3'h6

// ----------------------------------------
// timing
// ----------------------------------------
`define FC_CLK_NS      20
`define FC_T_WP_NS     40
`define FC_T_ACC_NS    55
`define FC_WP_CYC      ((`FC_T_WP_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_ACC_CYC     ((`FC_T_ACC_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_T_EC_MS     10000
`define FC_POLL_LIMIT  (`FC_T_EC_MS * (1000000 / `FC_CLK_NS))

`endif

/* core/fc_pkg.sv */
// Purpose: types of the flash command sequencer
// Assumes: 17 address lines, 8 data lines
// Notes:   op order matches the command register codes
package fc_pkg;

  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_LOCK, OP_ID_IN, OP_ID_OUT, OP_LOCK_Q, OP_NONE
  } fc_op_t;

  typedef enum logic [2:0] {K_END, K_WR, K_RD, K_CHK, K_QRY, K_POLL} fc_kind_t;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_WSET, S_WPUL, S_WHLD, S_READ, S_GAP} fc_state_t;

  typedef struct packed {
    fc_kind_t    kind;
    logic [16:0] addr;
    logic [7:0]  data;
  } fc_step_t;

  // flash side pins, two signals for the data lines
  typedef struct packed {
    logic [16:0] address_lines;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [7:0]  data_lines;
    logic        data_lines_oe;
  } fc_pins_t;

endpackage

/* core/fc_top.sv */
// Purpose: host sequencer driving a parallel flash through its pins
// Assumes: flash data inputs synchronous to MCLK_IN; AXI4-Lite slave
// Notes:   one command at a time; completion found by polling
//
// Notes on behaviour
// RULE1: read with chip and output enable low
// RULE2: flash floats data when either enable high
// RULE3: erased bits read back as one
// RULE4: refuse program needing a zero-to-one change
// RULE5: chip erase only by six-write code
// RULE6: flash times erase; bounded by max erase time
// RULE7: locked boot sector survives chip erase
// RULE8: programming only clears bits, byte-wise
// RULE9: byte program by four writes, self-timed
// RULE10: address taken at later falling enable
// RULE11: data taken at earlier rising enable
// RULE12: program ends within byte program time
// RULE13: boot block spans 00000 to 01fff
// RULE14: locked boot block refuses erase, program
// RULE15: lockout is optional and permanent
// RULE16: lockout enabled by six command writes
// RULE17: id mode address 2 bit 0 lock state
// RULE18: exit id mode after lock check
// RULE19: command address/data pairs as listed
// RULE20: id entry three writes, exit f0
// RULE21: polled byte shows inverted bit 7
// RULE22: bit 6 toggles while busy
// RULE23: broken sequence returns flash to read
`include "fc_defines.svh"

module fc_top #(
  parameter int unsigned POLL_LIMIT = `FC_POLL_LIMIT
) (
  input  wire logic            MCLK_IN,
  input  wire logic            NRST_IN,
  input  wire logic [31:0]     S_AXI_AWADDR_IN,
  input  wire logic            S_AXI_AWVALID_IN,
  output logic                 S_AXI_AWREADY_OUT,
  input  wire logic [31:0]     S_AXI_WDATA_IN,
  input  wire logic [3:0]      S_AXI_WSTRB_IN,
  input  wire logic            S_AXI_WVALID_IN,
  output logic                 S_AXI_WREADY_OUT,
  output logic [1:0]           S_AXI_BRESP_OUT,
  output logic                 S_AXI_BVALID_OUT,
  input  wire logic            S_AXI_BREADY_IN,
  input  wire logic [31:0]     S_AXI_ARADDR_IN,
  input  wire logic            S_AXI_ARVALID_IN,
  output logic                 S_AXI_ARREADY_OUT,
  output logic [31:0]          S_AXI_RDATA_OUT,
  output logic [1:0]           S_AXI_RRESP_OUT,
  output logic                 S_AXI_RVALID_OUT,
  input  wire logic            S_AXI_RREADY_IN,
  output fc_pkg::fc_pins_t     FL_PINS_OUT,
  input  wire logic [7:0]      FL_DQ_IN
);
  import fc_pkg::*;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic fc_step_t wr(input logic [16:0] a, input logic [7:0] d);
    return '{kind: K_WR, addr: a, data: d};
  endfunction

  // step idx of command op; K_END closes every sequence
  function automatic fc_step_t get_step(input fc_op_t op, input logic [2:0] idx,
                                        input logic [16:0] ta, input logic [7:0] td);
    fc_step_t s;
    logic [2:0] j;
    s = '{kind: K_END, addr: '0, data: '0};
    j = (op == OP_PROG) ? idx - 3'h1 : idx;
    // common unlock pair [RULE19] [RULE20]
    if (op != OP_READ && op != OP_ID_OUT && j == 3'h0 && !(op == OP_PROG && idx == 3'h0)) begin
      s = wr(`FC_ADDR_U1, `FC_DAT_U1);
    end else if (op != OP_READ && op != OP_ID_OUT && j == 3'h1) begin
      s = wr(`FC_ADDR_U2, `FC_DAT_U2);
    end else begin
      unique case (op)
        OP_READ:   if (idx == 3'h0) s = '{kind: K_RD, addr: ta, data: '0};  // [RULE1]
        OP_PROG: begin
          unique case (idx)
            3'h0: s = '{kind: K_CHK, addr: ta, data: td};                  // [RULE4] [RULE8]
            3'h3: s = wr(`FC_ADDR_U1, `FC_CMD_PROG);                       // [RULE9]
            3'h4: s = wr(ta, td);                                          // [RULE9]
            3'h5: s = '{kind: K_POLL, addr: ta, data: td};                 // [RULE12]
            default: s = '{kind: K_END, addr: '0, data: '0};
          endcase
        end
        OP_ERASE, OP_LOCK: begin
          unique case (idx)
            3'h2: s = wr(`FC_ADDR_U1, `FC_CMD_SETUP);
            3'h3: s = wr(`FC_ADDR_U1, `FC_DAT_U1);
            3'h4: s = wr(`FC_ADDR_U2, `FC_DAT_U2);
            // six-write erase or lockout code [RULE5] [RULE16] [RULE15]
            3'h5: s = wr(`FC_ADDR_U1, (op == OP_ERASE) ? `FC_CMD_ERASE : `FC_CMD_LOCK);
            3'h6: s = '{kind: K_POLL, addr: `FC_ADDR_ANY, data: '0};       // [RULE6]
            default: s = '{kind: K_END, addr: '0, data: '0};
          endcase
        end
        OP_ID_IN:  if (idx == 3'h2) s = wr(`FC_ADDR_U1, `FC_CMD_ID);       // [RULE20]
        OP_ID_OUT: if (idx == 3'h0) s = wr(`FC_ADDR_ANY, `FC_CMD_EXIT);    // [RULE20]
        OP_LOCK_Q: begin
          unique case (idx)
            3'h2: s = wr(`FC_ADDR_U1, `FC_CMD_ID);
            3'h3: s = '{kind: K_QRY, addr: `FC_ADDR_LOCKQ, data: '0};      // [RULE17]
            3'h4: s = wr(`FC_ADDR_ANY, `FC_CMD_EXIT);                      // [RULE18]
            default: s = '{kind: K_END, addr: '0, data: '0};
          endcase
        end
        default: s = '{kind: K_END, addr: '0, data: '0};
      endcase
    end
    return s;
  endfunction

  // ----------------------------------------
  // signals
  // ----------------------------------------
  fc_state_t   state;
  fc_op_t      op;
  fc_step_t    stp;
  logic [2:0]  idx;
  logic [2:0]  cnt;
  logic [31:0] poll_cnt;
  logic        have_prev;
  logic        prev6;
  logic [16:0] tgt_addr;
  logic [7:0]  tgt_data;
  logic [7:0]  rd_byte;
  logic        busy;
  logic        done;
  logic        err_to;
  logic        err_chk;
  logic        err_op;
  logic        locked;
  logic        start;
  logic        bad_op;
  logic        ev_done;
  logic        ev_to;
  logic        ev_chk;
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_a;
  logic [31:0] w_d;
  logic [3:0]  w_s;
  logic        do_write;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign busy = (state != S_IDLE);
  assign stp  = get_step(op, idx, tgt_addr, tgt_data);

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign S_AXI_AWREADY_OUT = !aw_held;
  assign S_AXI_WREADY_OUT  = !w_held;
  assign do_write          = aw_held && w_held && !S_AXI_BVALID_OUT;
  assign start  = do_write && aw_a == `FC_REG_CMD && !busy && w_s[0] && w_d[2:0] <= `FC_OP_LAST;
  assign bad_op = do_write && aw_a == `FC_REG_CMD && !busy && w_s[0] && w_d[2:0] > `FC_OP_LAST;

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_a             <= '0;
      w_d              <= '0;
      w_s              <= '0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= 2'h0;
    end else begin
      if (S_AXI_AWVALID_IN && !aw_held) begin
        aw_held <= 1'b1;
        aw_a    <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && !w_held) begin
        w_held <= 1'b1;
        w_d    <= S_AXI_WDATA_IN;
        w_s    <= S_AXI_WSTRB_IN;
      end
      if (do_write) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= (aw_a == `FC_REG_CMD || aw_a == `FC_REG_ADDR ||
                             aw_a == `FC_REG_WDATA || aw_a == `FC_REG_STATUS ||
                             aw_a == `FC_REG_RDATA) ? 2'h0 : 2'h2;
      end else if (S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // target registers, frozen while busy
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tgt_addr <= '0;
      tgt_data <= '0;
    end else if (do_write && !busy) begin
      if (aw_a == `FC_REG_ADDR) begin
        tgt_addr <= 17'(merge({15'h0000, tgt_addr}, w_d, w_s));
      end
      if (aw_a == `FC_REG_WDATA) begin
        tgt_data <= 8'(merge({24'h000000, tgt_data}, w_d, w_s));
      end
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
  always_comb begin
    status_word                 = '0;
    status_word[`FC_ST_BUSY]    = busy;
    status_word[`FC_ST_DONE]    = done;
    status_word[`FC_ST_ERR_TO]  = err_to;
    status_word[`FC_ST_ERR_CHK] = err_chk;
    status_word[`FC_ST_ERR_OP]  = err_op;
    status_word[`FC_ST_LOCKED]  = locked;
    rd_ok   = 1'b1;
    rd_word = '0;
    unique case (S_AXI_ARADDR_IN)
      `FC_REG_CMD:    rd_word = {29'h0, op};
      `FC_REG_ADDR:   rd_word = {15'h0, tgt_addr};
      `FC_REG_WDATA:  rd_word = {24'h0, tgt_data};
      `FC_REG_STATUS: rd_word = status_word;
      `FC_REG_RDATA:  rd_word = {24'h0, rd_byte};
      default:        rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= '0;
      S_AXI_RRESP_OUT  <= 2'h0;
    end else if (S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT  <= rd_word;
      S_AXI_RRESP_OUT  <= rd_ok ? 2'h0 : 2'h2;
    end else if (S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // ----------------------------------------
  // status flags, cleared by a new command
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      done    <= 1'b0;
      err_to  <= 1'b0;
      err_chk <= 1'b0;
      err_op  <= 1'b0;
    end else begin
      done    <= ev_done || (done && !start);
      err_to  <= ev_to || (err_to && !start);
      err_chk <= ev_chk || (err_chk && !start);
      err_op  <= bad_op || (err_op && !start);
    end
  end

  // ----------------------------------------
  // pin sequencer
  // ----------------------------------------
  assign ev_done = (state == S_FETCH) && (stp.kind == K_END);
  assign ev_chk  = (state == S_READ) && (cnt == 3'(`FC_ACC_CYC - 1)) && (stp.kind == K_CHK) &&
                   ((~FL_DQ_IN & stp.data) != 8'h00);
  assign ev_to   = (state == S_READ) && (cnt == 3'(`FC_ACC_CYC - 1)) &&
                   (stp.kind == K_POLL) && (poll_cnt >= POLL_LIMIT);

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state       <= S_IDLE;
      op          <= OP_NONE;
      idx         <= '0;
      cnt         <= '0;
      poll_cnt    <= '0;
      have_prev   <= 1'b0;
      prev6       <= 1'b0;
      rd_byte     <= '0;
      locked      <= 1'b0;
      FL_PINS_OUT <= '{address_lines: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                       data_lines: '0, data_lines_oe: 1'b0};
    end else begin
      if (busy && stp.kind == K_POLL) begin
        poll_cnt <= poll_cnt + 32'h1;
      end
      unique case (state)
        S_IDLE: if (start) begin
          op        <= fc_op_t'(w_d[2:0]);
          idx       <= '0;
          poll_cnt  <= '0;
          have_prev <= 1'b0;
          state     <= S_FETCH;
        end
        S_FETCH: begin
          cnt <= '0;
          FL_PINS_OUT.address_lines <= stp.addr;
          unique case (stp.kind)
            K_END: state <= S_IDLE;
            K_WR: begin
              // flash sees only ce low yet; oe stays high [RULE2]
              FL_PINS_OUT.data_lines    <= stp.data;
              FL_PINS_OUT.data_lines_oe <= 1'b1;
              FL_PINS_OUT.ce_n          <= 1'b0;
              state                     <= S_WSET;
            end
            K_RD, K_CHK, K_QRY, K_POLL: begin
              FL_PINS_OUT.ce_n <= 1'b0;                                   // [RULE1]
              FL_PINS_OUT.oe_n <= 1'b0;
              state            <= S_READ;
            end
          endcase
        end
        S_WSET: begin
          FL_PINS_OUT.we_n <= 1'b0;                                        // [RULE10]
          state            <= S_WPUL;
        end
        S_WPUL: if (cnt == 3'(`FC_WP_CYC - 1)) begin
          FL_PINS_OUT.we_n <= 1'b1;                                        // [RULE11]
          state            <= S_WHLD;
        end else begin
          cnt <= cnt + 3'h1;
        end
        S_WHLD: begin
          FL_PINS_OUT.ce_n          <= 1'b1;
          FL_PINS_OUT.data_lines_oe <= 1'b0;
          idx                       <= idx + 3'h1;
          state                     <= S_GAP;
        end
        S_READ: if (cnt == 3'(`FC_ACC_CYC - 1)) begin
          FL_PINS_OUT.ce_n <= 1'b1;
          FL_PINS_OUT.oe_n <= 1'b1;
          rd_byte          <= FL_DQ_IN;
          state            <= S_GAP;
          unique case (stp.kind)
            K_RD:  idx <= idx + 3'h1;                                      // [RULE3]
            // refused before any write; flash stays in read [RULE4] [RULE23]
            K_CHK: begin
              if (ev_chk) begin
                state <= S_IDLE;
              end else begin
                idx <= idx + 3'h1;
              end
            end
            K_QRY: begin
              locked <= FL_DQ_IN[0];                                       // [RULE17] [RULE13]
              idx    <= idx + 3'h1;
            end
            K_POLL: begin
              // done when bit 6 stops toggling [RULE22] [RULE12]
              if (ev_to) begin
                state <= S_IDLE;                                           // [RULE6]
              end else if (have_prev && prev6 == FL_DQ_IN[6]) begin
                idx <= idx + 3'h1;
              end
              have_prev <= 1'b1;
              prev6     <= FL_DQ_IN[6];
            end
            default: state <= S_IDLE;
          endcase
        end else begin
          cnt <= cnt + 3'h1;
        end
        S_GAP: state <= S_FETCH;
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

/* testbench/fc_properties.sv */
// Purpose: pin-level checks of the flash sequencer
// Assumes: one clock domain, async active-low reset
// Notes:   bound onto fc_top, sees only its ports
module fc_properties (
  input wire logic             MCLK_IN,
  input wire logic             NRST_IN,
  input wire fc_pkg::fc_pins_t FL_PINS_OUT
);
  import fc_pkg::*;
  fc_pins_t   p;
  logic [1:0] unl;
  assign p = FL_PINS_OUT;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);
  // ----------------------------------------
  // last write was an unlock step
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      unl <= 2'h0;
    end else if ($fell(p.we_n)) begin
      unl <= {p.address_lines == 17'h02aaa && p.data_lines == 8'h55,
              p.address_lines == 17'h05555 && p.data_lines == 8'haa};
    end
  end
  a_no_contention : assert property (p.data_lines_oe |-> p.oe_n)
    else $error("data driven while flash outputs on");
  a_write_frame : assert property (!p.we_n |-> !p.ce_n && p.oe_n && p.data_lines_oe)
    else $error("write strobe without chip select or data");
  a_we_pulse : assert property ($fell(p.we_n) |-> ##1 !p.we_n ##1 (p.we_n && !p.ce_n))
    else $error("write pulse length wrong");
  a_addr_hold : assert property (!p.we_n |=> $stable(p.address_lines))
    else $error("address moved during write");
  a_data_hold : assert property (
      $rose(p.we_n) |-> p.data_lines_oe && !p.ce_n && $stable(p.data_lines))
    else $error("data not held at write end");
  a_read_cycle : assert property (
      $fell(p.oe_n) |-> (!p.oe_n && !p.ce_n && p.we_n)[*3] ##1 p.oe_n)
    else $error("read cycle shape wrong");
  a_unlock_two : assert property (
      $fell(p.we_n) && unl[0] |-> p.address_lines == 17'h02aaa && p.data_lines == 8'h55)
    else $error("second unlock write wrong");
  a_unlock_cmd : assert property (
      $fell(p.we_n) && unl[1] |-> p.address_lines == 17'h05555)
    else $error("command write not at 5555");
endmodule

bind fc_top fc_properties u_props (
  .MCLK_IN     (MCLK_IN),
  .NRST_IN     (NRST_IN),
  .FL_PINS_OUT (FL_PINS_OUT)
);

/* testbench/fc_flash_model.sv */
// Purpose: behavioural parallel flash on the sequencer pins
// Assumes: short program and erase times for simulation
// Notes:   undriven data handled by the bench
module fc_flash_model #(
  parameter int PROG_NS  = 400,
  parameter int ERASE_NS = 1500
) (
  input wire logic [16:0] addr_in,
  input wire logic        ce_n_in,
  input wire logic        oe_n_in,
  input wire logic        we_n_in,
  input wire logic [7:0]  dq_in,
  output logic [7:0]      dq_out,
  output logic            dq_drv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:131071];
  logic [16:0] la = 17'h0;
  logic [7:0]  ld = 8'hff;
  logic [2:0]  st = 3'h0;
  logic        lk = 1'b0, idm = 1'b0, busy = 1'b0, tog = 1'b0;
  int          bt = 0;
  wire wr = !ce_n_in && !we_n_in;
  wire rd = !ce_n_in && !oe_n_in && we_n_in;
  wire u1 = la == 17'h05555;
  wire u2 = la == 17'h02aaa;
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(posedge wr) la = addr_in;
  // ----------------------------------------
  // command interpreter, data at write end
  // ----------------------------------------
  always @(negedge wr) if (!busy) begin
    case (st)
      3'd0: begin
        if (dq_in == 8'hf0) idm = 1'b0;
        st = (u1 && dq_in == 8'haa) ? 3'd1 : 3'd0;
      end
      3'd1: st = (u2 && dq_in == 8'h55) ? 3'd2 : 3'd0;
      3'd2: begin
        st = (u1 && dq_in == 8'ha0) ? 3'd3 : (u1 && dq_in == 8'h80) ? 3'd4 : 3'd0;
        if (u1 && dq_in == 8'h90) idm = 1'b1;
        if (u1 && dq_in == 8'hf0) idm = 1'b0;
      end
      3'd3: begin
        st = 3'd0;
        ld = dq_in;
        if (!(lk && la < 17'h02000)) begin
          mem[la] = mem[la] & dq_in;
          bt = PROG_NS;
          busy = 1'b1;
        end
      end
      3'd4: st = (u1 && dq_in == 8'haa) ? 3'd5 : 3'd0;
      3'd5: st = (u2 && dq_in == 8'h55) ? 3'd6 : 3'd0;
      3'd6: begin
        st = 3'd0;
        if (u1 && dq_in == 8'h40) lk = 1'b1;
        if (u1 && dq_in == 8'h10) begin
          foreach (mem[i]) if (!lk || i >= 32'h2000) mem[i] = 8'hff;
          ld = 8'hff;
          bt = ERASE_NS;
          busy = 1'b1;
        end
      end
      default: st = 3'd0;
    endcase
  end
  always @(posedge busy) #(bt) busy = 1'b0;
  always @(posedge rd) if (busy) tog = ~tog;
  assign dq_drv_out = rd;
  assign dq_out = busy ? {~ld[7], tog, ld[5:0]} :
                  (idm && addr_in == 17'h00002) ? {7'h0, lk} : mem[addr_in];
endmodule

/* testbench/fc_top_tb.sv */
// Purpose: self-checking bench for fc_top
// Assumes: flash model on the pins, AXI4-Lite master tasks
// Notes:   results compared from queues by a monitor
`include "fc_defines.svh"
module fc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, aw_valid = 1'b0, w_valid = 1'b0;
  logic        b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic [31:0] aw_addr = 32'h0, w_data = 32'h0, ar_addr = 32'h0, r_data, v;
  logic [1:0]  b_resp, r_resp;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, drv;
  logic [7:0]  fdq, dq, last_w = 8'h00, d1, d2;
  fc_pins_t    pins;
  logic [65:0] q_r[$], e;
  logic [1:0]  q_b[$];
  integer      seed, mismatches = 0, checks_done = 0;
  always #10 clk = ~clk;
  always @(posedge clk) last_w <= dq;
  assign dq = pins.data_lines_oe ? pins.data_lines : drv ? fdq : ~last_w;
  fc_top #(.POLL_LIMIT(200)) u_dut (
    .MCLK_IN (clk), .NRST_IN (rst_n),
    .S_AXI_AWADDR_IN (aw_addr), .S_AXI_AWVALID_IN (aw_valid), .S_AXI_AWREADY_OUT (aw_ready),
    .S_AXI_WDATA_IN (w_data), .S_AXI_WSTRB_IN (4'hf), .S_AXI_WVALID_IN (w_valid),
    .S_AXI_WREADY_OUT (w_ready), .S_AXI_BRESP_OUT (b_resp), .S_AXI_BVALID_OUT (b_valid),
    .S_AXI_BREADY_IN (b_ready), .S_AXI_ARADDR_IN (ar_addr), .S_AXI_ARVALID_IN (ar_valid),
    .S_AXI_ARREADY_OUT (ar_ready), .S_AXI_RDATA_OUT (r_data), .S_AXI_RRESP_OUT (r_resp),
    .S_AXI_RVALID_OUT (r_valid), .S_AXI_RREADY_IN (r_ready), .FL_PINS_OUT (pins),
    .FL_DQ_IN (dq)
  );
  fc_flash_model u_flash (
    .addr_in (pins.address_lines), .ce_n_in (pins.ce_n), .oe_n_in (pins.oe_n),
    .we_n_in (pins.we_n), .dq_in (dq), .dq_out (fdq), .dq_drv_out (drv)
  );
  // ----------------------------------------
  // monitor and bus tasks
  // ----------------------------------------
  always @(posedge clk) begin
    if (r_valid === 1'b1 && r_ready) begin
      e = q_r.pop_front();
      checks_done++;
      if ({r_resp, r_data & e[31:0]} !== {e[65:64], e[63:32] & e[31:0]}) begin
        mismatches++;
        $display("[ERR] %0t read want %h got %h", $time, e[63:32], r_data);
      end
    end
    if (b_valid === 1'b1 && b_ready) begin
      checks_done++;
      if (b_resp !== q_b.pop_front()) begin
        mismatches++;
        $display("[ERR] %0t write response %h", $time, b_resp);
      end
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    int n;
    n = 0;
    q_b.push_back(r);
    @(posedge clk);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_ready) aw_valid <= 1'b0;
      if (w_ready) w_valid <= 1'b0;
      n++;
    end while (b_valid !== 1'b1 && n < 100);
    b_ready <= 1'b0;
    if (n >= 100) timeout();
  endtask
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m,
                        input logic [1:0] r = 2'b00);
    int n;
    n = 0;
    q_r.push_back({r, x, m});
    @(posedge clk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_ready) ar_valid <= 1'b0;
      n++;
    end while (r_valid !== 1'b1 && n < 100);
    v = r_data;
    r_ready <= 1'b0;
    if (n >= 100) timeout();
  endtask
  task automatic run(input logic [2:0] op, input logic [16:0] ad, input logic [7:0] wd,
                     input logic [5:0] sv, input logic [5:0] sm);
    int k;
    axi_wr(`FC_REG_ADDR, {15'h0, ad});
    axi_wr(`FC_REG_WDATA, {24'h0, wd});
    axi_wr(`FC_REG_CMD, {29'h0, op});
    for (k = 0; k < 400; k++) begin
      axi_rd(`FC_REG_STATUS, 32'h0, 32'h0);
      if (v[0] === 1'b0) break;
    end
    if (k >= 400) timeout();
    axi_rd(`FC_REG_STATUS, {26'h0, sv}, {26'h0, sm});
  endtask
  task automatic rdb(input logic [16:0] ad, input logic [7:0] x, input logic [7:0] m = 8'hff);
    run(3'h0, ad, 8'h00, 6'h02, 6'h1f);
    axi_rd(`FC_REG_RDATA, {24'h0, x}, {24'h0, m});
  endtask
  initial begin
    seed = 73515;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    d1 = 8'($random(seed)) & 8'hfe;
    d2 = 8'($random(seed)) & 8'h7e;
    axi_wr(32'h20, 32'h0, 2'b10);
    axi_rd(32'h20, 32'h0, 32'hffffffff, 2'b10);
    run(3'h7, 17'h0, 8'h00, 6'h10, 6'h11);
    run(3'h6, 17'h0, 8'h00, 6'h02, 6'h3f);
    run(3'h1, 17'h00100, d1, 6'h02, 6'h1f);
    run(3'h1, 17'h03000, d2, 6'h02, 6'h1f);
    rdb(17'h00100, d1);
    run(3'h1, 17'h03000, 8'hff, 6'h08, 6'h0d);
    run(3'h1, 17'h03000, d2 & 8'h0f, 6'h02, 6'h1f);
    rdb(17'h03000, d2 & 8'h0f);
    run(3'h3, 17'h0, 8'h00, 6'h02, 6'h1f);
    run(3'h2, 17'h0, 8'h00, 6'h02, 6'h1f);
    run(3'h6, 17'h0, 8'h00, 6'h22, 6'h3f);
    rdb(17'h03000, 8'hff);
    rdb(17'h00100, d1);
    run(3'h1, 17'h01fff, 8'h5a, 6'h00, 6'h01);
    run(3'h1, 17'h02000, 8'h5a, 6'h02, 6'h1f);
    rdb(17'h01fff, 8'hff);
    rdb(17'h02000, 8'h5a);
    run(3'h4, 17'h0, 8'h00, 6'h02, 6'h1f);
    rdb(17'h00002, 8'h01, 8'h01);
    run(3'h5, 17'h0, 8'h00, 6'h02, 6'h1f);
    rdb(17'h02000, 8'h5a);
    give_verdict();
  end
endmodule
